// ---- design/pwmcs_pkg.sv ----
// Package with register map, field positions and reset values of the PWM core
package pwmcs_pkg;
  // Channel count and data width
  localparam int NCH = 8;
  localparam int DW = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_RUN = 8'h00;
  localparam logic [7:0] ADDR_POL = 8'h04;
  localparam logic [7:0] ADDR_CAE = 8'h08;
  localparam logic [7:0] ADDR_SDN = 8'h0c;
  // Per-channel arrays: base in bits [7:5], channel in [4:2]
  localparam logic [2:0] BASE_CNT = 3'h1;
  localparam logic [2:0] BASE_PER = 3'h2;
  localparam logic [2:0] BASE_DTY = 3'h3;
  // Shutdown register fields
  localparam int SDN_FLAG = 7;
  localparam int SDN_IRQ = 6;
  localparam int SDN_RESTART = 5;
  localparam int SDN_LVL = 4;
  localparam int SDN_PIN = 2;
  localparam int SDN_POL = 1;
  localparam int SDN_EN = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ONE = 8'h01;
  // Index of the channel whose pin doubles as shutdown input
  localparam int SDN_CH = 7;
endpackage

// ---- design/pwmcs_top.sv ----
// Eight-channel PWM counter core with emergency shutdown and APB registers
//
// Behaviour
// [RULE_01] Each channel has 8-bit up/down counter
// [RULE_02] Counter reads never disturb counting
// [RULE_03] Left-aligned counts 0 to period minus one
// [RULE_04] Center-aligned counts up to period, back down
// [RULE_05] Counter write clears, counts up, reloads, repolarises
// [RULE_06] Counter clears at effective period end
// [RULE_07] Disabled counter holds, resumes on enable
// [RULE_08] Output period is tick times period, doubled centered
// [RULE_09] Zero period gives constant start polarity
// [RULE_10] Duty match toggles the output
// [RULE_11] Zero duty gives constant inverted polarity
// [RULE_12] High fraction follows polarity, duty, period
// [RULE_13] Shutdown bits ignored while feature is off
// [RULE_14] Pin change sets flag, write one clears
// [RULE_15] Flag with irq allow raises interrupt request
// [RULE_16] Restart bit self-clears, reads zero
// [RULE_17] After shutdown, outputs resume at counter zero
// [RULE_18] Active shutdown forces outputs to chosen level
// [RULE_19] Status bit shows channel seven pin level
// [RULE_20] Polarity bit selects shutdown input active level
// [RULE_21] Enable bit makes channel seven pin input
// [RULE_22] Period and duty double buffered
// [RULE_23] Polarity sets starting level of each cycle
// [RULE_24] Reserved bit three reads zero
// [RULE_25] Registers 8-bit, reached through bus slave
`timescale 1ns/1ps
`default_nettype none

module pwmcs_top
  import pwmcs_pkg::*;
#(
  parameter int CH = NCH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Selected channel clock, one pulse per tick
  input wire logic [CH-1:0] channel_clock_select,
  // PWM outputs
  output logic [CH-1:0] pwm_out,
  // Channel seven pin as three signals
  input wire logic channel_seven_pin_i,
  output logic channel_seven_pin_o,
  output logic channel_seven_pin_oe,
  // Shutdown interrupt request
  output logic shutdown_irq
);

  // Software control bits
  logic [CH-1:0] channel_run_ff;
  logic [CH-1:0] start_polarity_ff;
  logic [CH-1:0] center_align_on_ff;
  // Shutdown control fields
  logic shutdown_feature_on_ff;
  logic shutdown_irq_allow_ff;
  logic forced_output_state_ff;
  logic shutdown_active_polarity_ff;
  logic shutdown_flag_ff;
  // Previous pin level for change detection
  logic pin_prev_ff;
  // Read data register
  logic [31:0] prdata_ff;

  // Bus decode
  logic acc;
  logic wr;
  logic [2:0] base;
  logic [2:0] idx;
  logic arr_hit;
  logic hit;
  logic [DW-1:0] wdat;
  logic [DW-1:0] rd_sel;

  // Per-channel state
  logic [DW-1:0] cnt_ff [CH];
  logic [DW-1:0] per_buf_ff [CH];
  logic [DW-1:0] dty_buf_ff [CH];
  logic [DW-1:0] per_act_ff [CH];
  logic [DW-1:0] dty_act_ff [CH];
  logic [CH-1:0] down_ff;
  logic [CH-1:0] wave_ff;
  logic [CH-1:0] stop_ff;
  logic [CH-1:0] pwm_ff;

  // Shutdown is asserted when enabled and pin at active level
  logic sdn_active;
  logic [7:0] sdn_rd;

  // Writes take effect in the access phase, reads sample in the setup phase; zero wait states
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign base = paddr[7:5];
  assign idx = paddr[4:2];
  assign wdat = pwdata[DW-1:0];
  // Array entries answer only at word-aligned byte addresses
  assign arr_hit = ((base == BASE_CNT) | (base == BASE_PER) | (base == BASE_DTY))
                 & (paddr[1:0] == 2'h0);
  // Array entries beyond the channel count are unmapped
  assign hit = (paddr == ADDR_RUN) | (paddr == ADDR_POL) | (paddr == ADDR_CAE)
             | (paddr == ADDR_SDN) | (arr_hit & (32'(idx) < CH));
  assign pready = 1'b1; // RULE_25
  assign pslverr = acc & ~hit;
  assign prdata = prdata_ff;

  // Shutdown condition, ignored while the feature is off
  assign sdn_active = shutdown_feature_on_ff
    & (channel_seven_pin_i == shutdown_active_polarity_ff); // RULE_13 RULE_20

  // Shutdown register readback; restart and bit 3 read zero
  always_comb begin
    sdn_rd = RST_BYTE;
    sdn_rd[SDN_FLAG] = shutdown_flag_ff;
    sdn_rd[SDN_IRQ] = shutdown_irq_allow_ff;
    sdn_rd[SDN_LVL] = forced_output_state_ff;
    sdn_rd[SDN_PIN] = channel_seven_pin_i; // RULE_19
    sdn_rd[SDN_POL] = shutdown_active_polarity_ff;
    sdn_rd[SDN_EN] = shutdown_feature_on_ff; // RULE_24 RULE_16
  end

  // Read multiplexer
  always_comb begin
    rd_sel = RST_BYTE;
    if (paddr == ADDR_RUN) begin
      rd_sel = channel_run_ff;
    end else if (paddr == ADDR_POL) begin
      rd_sel = start_polarity_ff;
    end else if (paddr == ADDR_CAE) begin
      rd_sel = center_align_on_ff;
    end else if (paddr == ADDR_SDN) begin
      rd_sel = sdn_rd;
    end else if (hit && base == BASE_CNT) begin
      // Plain read, no side effect on the count
      rd_sel = cnt_ff[idx]; // RULE_02
    end else if (hit && base == BASE_PER) begin
      rd_sel = per_buf_ff[idx];
    end else if (hit && base == BASE_DTY) begin
      rd_sel = dty_buf_ff[idx];
    end
  end

  // Read data captured in the setup phase, narrow data in low bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= {24'h00_0000, rd_sel}; // RULE_25
    end
  end

  // Global control registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      channel_run_ff <= RST_BYTE;
      start_polarity_ff <= RST_BYTE;
      center_align_on_ff <= RST_BYTE;
    end else if (wr) begin
      if (paddr == ADDR_RUN) begin
        channel_run_ff <= wdat;
      end
      if (paddr == ADDR_POL) begin
        start_polarity_ff <= wdat;
      end
      if (paddr == ADDR_CAE) begin
        center_align_on_ff <= wdat;
      end
    end
  end

  // Shutdown control fields
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shutdown_feature_on_ff <= 1'b0;
      shutdown_irq_allow_ff <= 1'b0;
      forced_output_state_ff <= 1'b0;
      shutdown_active_polarity_ff <= 1'b0;
    end else if (wr && paddr == ADDR_SDN) begin
      shutdown_feature_on_ff <= wdat[SDN_EN]; // RULE_21
      shutdown_irq_allow_ff <= wdat[SDN_IRQ];
      forced_output_state_ff <= wdat[SDN_LVL];
      shutdown_active_polarity_ff <= wdat[SDN_POL]; // RULE_20
    end
  end

  // Pin change flag; a change in the clearing cycle keeps it set
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_prev_ff <= 1'b0;
      shutdown_flag_ff <= 1'b0;
    end else begin
      pin_prev_ff <= channel_seven_pin_i;
      if (shutdown_feature_on_ff && channel_seven_pin_i != pin_prev_ff) begin
        shutdown_flag_ff <= 1'b1; // RULE_14 RULE_13
      end else if (wr && paddr == ADDR_SDN && wdat[SDN_FLAG]) begin
        shutdown_flag_ff <= 1'b0; // RULE_14
      end
    end
  end

  // Interrupt request, a level
  assign shutdown_irq = shutdown_flag_ff & shutdown_irq_allow_ff
                      & shutdown_feature_on_ff; // RULE_15

  // Channel seven pin turns input while shutdown is enabled
  assign channel_seven_pin_oe = ~shutdown_feature_on_ff; // RULE_21
  assign channel_seven_pin_o = pwm_ff[SDN_CH];
  assign pwm_out = pwm_ff;

  // One timer per channel
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      // Write strobes for this channel
      logic w_cnt;
      logic w_per;
      logic w_dty;
      logic tick;
      logic zero_evt;
      logic lend;
      logic cturn;
      logic cend;
      logic [DW-1:0] nxt_cnt;
      logic nxt_down;
      logic wave;

      assign w_cnt = wr && hit && base == BASE_CNT && 32'(idx) == g;
      assign w_per = wr && hit && base == BASE_PER && 32'(idx) == g;
      assign w_dty = wr && hit && base == BASE_DTY && 32'(idx) == g;
      // Counter advances only while enabled
      assign tick = channel_run_ff[g] & channel_clock_select[g]; // RULE_01 RULE_07
      // Left-aligned end: counter at period minus one
      assign lend = (cnt_ff[g] >= per_act_ff[g] - ONE); // RULE_03
      // Center-aligned turn at period, end on reaching zero
      assign cturn = ~down_ff[g] & (cnt_ff[g] >= per_act_ff[g]); // RULE_04
      assign cend = (down_ff[g] & (cnt_ff[g] <= ONE)) | (per_act_ff[g] == RST_BYTE);
      assign zero_evt = w_cnt | (tick & (center_align_on_ff[g] ? cend : lend));

      // Next count and direction for one tick
      always_comb begin
        nxt_cnt = cnt_ff[g] + ONE;
        nxt_down = down_ff[g];
        if (center_align_on_ff[g]) begin
          if (cend) begin
            // Period ends twice as long as left-aligned
            nxt_cnt = RST_BYTE; // RULE_08 RULE_06
            nxt_down = 1'b0;
          end else if (cturn || down_ff[g]) begin
            nxt_cnt = cnt_ff[g] - ONE;
            nxt_down = 1'b1;
          end
        end else if (lend) begin
          nxt_cnt = RST_BYTE; // RULE_06 RULE_08
          nxt_down = 1'b0;
        end
      end

      // Counter and direction
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cnt_ff[g] <= RST_BYTE;
          down_ff[g] <= 1'b0;
        end else if (w_cnt) begin
          // Any written value clears and counts up
          cnt_ff[g] <= RST_BYTE; // RULE_05
          down_ff[g] <= 1'b0;
        end else if (tick) begin
          cnt_ff[g] <= nxt_cnt;
          down_ff[g] <= nxt_down;
        end
      end

      // Buffers take every write
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          per_buf_ff[g] <= RST_BYTE;
          dty_buf_ff[g] <= RST_BYTE;
        end else begin
          if (w_per) begin
            per_buf_ff[g] <= wdat;
          end
          if (w_dty) begin
            dty_buf_ff[g] <= wdat;
          end
        end
      end

      // Active values load at period end, counter write or while disabled
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          per_act_ff[g] <= RST_BYTE;
          dty_act_ff[g] <= RST_BYTE;
        end else if (!channel_run_ff[g]) begin
          // Disabled: writes go straight through
          per_act_ff[g] <= w_per ? wdat : per_buf_ff[g]; // RULE_22
          dty_act_ff[g] <= w_dty ? wdat : dty_buf_ff[g];
        end else if (zero_evt) begin
          per_act_ff[g] <= per_buf_ff[g]; // RULE_22 RULE_05
          dty_act_ff[g] <= dty_buf_ff[g];
        end
      end

      // Waveform flip-flop: starts at polarity, toggles on duty match
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          wave_ff[g] <= 1'b0;
        end else if (zero_evt) begin
          wave_ff[g] <= start_polarity_ff[g]; // RULE_23 RULE_05
        end else if (tick && nxt_cnt == dty_act_ff[g]) begin
          wave_ff[g] <= ~wave_ff[g]; // RULE_10 RULE_12
        end
      end

      // Boundary values override the toggling waveform
      always_comb begin
        wave = wave_ff[g];
        if (per_act_ff[g] == RST_BYTE) begin
          wave = start_polarity_ff[g]; // RULE_09
        end else if (dty_act_ff[g] == RST_BYTE) begin
          wave = ~start_polarity_ff[g]; // RULE_11
        end
      end

      // Shutdown hold: set while active, released at next counter zero
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stop_ff[g] <= 1'b0;
        end else if (sdn_active) begin
          stop_ff[g] <= 1'b1;
        end else if (zero_evt || !shutdown_feature_on_ff) begin
          // Turning the feature off drops any pending hold
          stop_ff[g] <= 1'b0; // RULE_17 RULE_16 RULE_13
        end
      end

      // Registered pin level; shutdown forces the chosen level
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          pwm_ff[g] <= 1'b0;
        end else if (sdn_active || (stop_ff[g] && shutdown_feature_on_ff)) begin
          // Forced level has no effect once the feature is off
          pwm_ff[g] <= forced_output_state_ff; // RULE_18
        end else begin
          pwm_ff[g] <= wave;
        end
      end
    end
  endgenerate

endmodule // pwmcs_top

`default_nettype wire

// ---- sim/pwmcs_chk.sv ----
// Port-level assertions for the PWM core
`timescale 1ns/1ps
`default_nettype none
module pwmcs_chk
  import pwmcs_pkg::*;
#(
  parameter int CH = NCH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CH-1:0] channel_clock_select,
  input wire logic [CH-1:0] pwm_out,
  input wire logic channel_seven_pin_i,
  input wire logic channel_seven_pin_o,
  input wire logic channel_seven_pin_oe,
  input wire logic shutdown_irq
);
  // Access phase of a write to the shutdown register
  logic wr_sdn;
  assign wr_sdn = psel && penable && pwrite && (paddr == ADDR_SDN);
  // Addresses with no register behind them
  logic bad_addr;
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr[7:4] == 4'h1) || paddr[7];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // No tick, no write and a steady pin for eight cycles
  sequence s_quiet;
    (channel_clock_select == '0 && !(psel && pwrite) && $stable(channel_seven_pin_i)) [*8];
  endsequence
  property p_hold; s_quiet |-> $stable(pwm_out); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while idle");
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; psel && penable |-> pslverr == bad_addr; endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_hi; prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_rd; $changed(prdata) |-> $past(psel && !penable && !pwrite); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_pin; channel_seven_pin_o == pwm_out[CH-1]; endproperty
  a_pin: assert property (p_pin) else $error("pin seven output differs");
  property p_oe; $changed(channel_seven_pin_oe) |-> $past(wr_sdn); endproperty
  a_oe: assert property (p_oe) else $error("pin direction moved");
  property p_irq; $fell(shutdown_irq) |-> $past(wr_sdn); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped unasked");
endmodule // pwmcs_chk
bind pwmcs_top pwmcs_chk #(.CH(CH)) i_pwmcs_chk (.clk_sys, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_clock_select, .pwm_out,
  .channel_seven_pin_i, .channel_seven_pin_o, .channel_seven_pin_oe, .shutdown_irq);
`default_nettype wire

// ---- sim/pwmcs_top_bench.sv ----
// Self-checking bench for the PWM core
`timescale 1ns/1ps
`default_nettype none
module pwmcs_top_bench import pwmcs_pkg::*;;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] channel_clock_select = 8'h00;
  logic ext_pin = 1'b0; // Level an outside source puts on pin seven
  logic [31:0] prdata;
  logic pready, pslverr, pin_o, pin_oe, shutdown_irq;
  logic [7:0] pwm_out;
  wire logic pin_w = pin_oe ? pin_o : ext_pin; // Wire level of pin seven
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] rd, c1; // Last read data, saved count
  logic er; // Last slave error
  int hi [4]; // High cycles per channel
  // Register rows: address, write data, read back, error
  localparam logic [7:0] RA [13] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h60, 8'h64, 8'h68,
    8'h6c, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h10};
  localparam logic [7:0] RW [13] = '{8'h03, 8'h04, 8'h00, 8'h04, 8'h01, 8'h01, 8'h02,
    8'h00, 8'h0d, 8'h02, 8'h28, 8'h77, 8'h55};
  localparam logic [7:0] RE [13] = '{8'h03, 8'h04, 8'h00, 8'h04, 8'h01, 8'h01, 8'h02,
    8'h00, 8'h0d, 8'h02, 8'h00, 8'h00, 8'h00};
  localparam logic [12:0] RX = 13'h1000;
  always #50 clk_sys = ~clk_sys;
  pwmcs_top i_pwmcs_top (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .channel_clock_select, .pwm_out, .channel_seven_pin_i(pin_w),
    .channel_seven_pin_o(pin_o), .channel_seven_pin_oe(pin_oe), .shutdown_irq);
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Value compare
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    while (n < 16) begin
      @(posedge clk_sys);
      n++;
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    chk(pready, 1'b1);
    if (pready !== 1'b1) tally_and_finish();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (shutdown_irq !== v && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk(shutdown_irq, v);
    if (shutdown_irq !== v) tally_and_finish();
  endtask
  // Count high cycles over 48 cycles
  task automatic measure;
    hi = '{4{0}};
    repeat (48) begin
      @(posedge clk_sys);
      for (int c = 0; c < 4; c++) hi[c] += pwm_out[c];
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    chk({pwm_out, shutdown_irq, pin_oe}, 33'h1);
    repeat (10) @(posedge clk_sys);
    // Table of ordinary register cases
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, RA[i], RW[i]);
      apb(1'b0, RA[i], 8'h00);
      chk({er, rd}, {RX[i], 24'h0, RE[i]});
    end
    // Four channels run on every cycle
    channel_clock_select <= 8'hff;
    apb(1'b1, ADDR_RUN, 8'h0f);
    repeat (20) @(posedge clk_sys);
    measure();
    chk(hi[0], 48 / 3);
    chk(hi[1], 48 * 3 / 4);
    chk(hi[2], 48);
    chk(hi[3], 0);
    // Period written while running takes effect at period end
    apb(1'b1, 8'h40, 8'h06);
    repeat (10) @(posedge clk_sys);
    measure();
    chk(hi[0], 48 / 6);
    // Stopped channel keeps its count
    apb(1'b1, ADDR_RUN, 8'h0d);
    apb(1'b0, 8'h24, 8'h00);
    c1 = rd;
    chk(c1 <= 4, 1'b1);
    repeat (9) @(posedge clk_sys);
    apb(1'b0, 8'h24, 8'h00);
    chk(rd, c1);
    // Shutdown armed, input active high, forced level one
    apb(1'b1, ADDR_SDN, 8'h53);
    chk(pin_oe, 1'b0);
    ext_pin <= 1'b1;
    wait_irq(1'b1);
    repeat (4) @(posedge clk_sys);
    chk(pwm_out, 8'hff);
    apb(1'b0, ADDR_SDN, 8'h00);
    chk(rd, 32'hd7);
    apb(1'b1, ADDR_SDN, 8'hd3);
    apb(1'b0, ADDR_SDN, 8'h00);
    chk({shutdown_irq, rd}, 33'h57);
    ext_pin <= 1'b0;
    wait_irq(1'b1);
    repeat (30) @(posedge clk_sys);
    chk(pwm_out[3], 1'b0);
    // Feature off keeps other bits inert
    apb(1'b1, ADDR_SDN, 8'hd0);
    apb(1'b0, ADDR_SDN, 8'h00);
    chk({shutdown_irq, rd}, 33'h50);
    // Active-low input with forced level zero
    apb(1'b1, ADDR_SDN, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk(pwm_out, 8'h00);
    // Mid-run reset returns outputs and registers to idle
    rstn <= 1'b0;
    @(posedge clk_sys);
    chk({pwm_out, shutdown_irq, pin_oe}, 33'h1);
    chk(prdata, 33'h0);
    rstn <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, ADDR_SDN, 8'h00);
    chk(rd, 33'h0);
    tally_and_finish();
  end
endmodule // pwmcs_top_bench
`default_nettype wire
